//--- memory_map_pkg.sv
package memory_map_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// Region boundaries of the 64 Kbyte space.
	localparam logic [15:0] IO_PAGE_LAST = 16'h005F;
	localparam logic [15:0] RAM_LAST = 16'h035F;
	localparam logic [15:0] GAP_LAST = 16'h7FFF;
	localparam logic [15:0] FLASH_LAST = 16'hFDFF;
	localparam logic [15:0] HIGH_IO_LAST = 16'hFE0F;
	localparam logic [15:0] MONITOR_LAST = 16'hFEFF;
	localparam logic [15:0] PROTECT_ADDR = 16'hFF7E;
	localparam logic [15:0] VECTOR_FIRST = 16'hFFD2;

	// Holes and reserved slots in the high I/O page.
	localparam logic [15:0] HIGH_RSV_A = 16'hFE02;
	localparam logic [15:0] HIGH_RSV_FIRST = 16'hFE04;
	localparam logic [15:0] HIGH_RSV_LAST = 16'hFE06;
	localparam logic [15:0] HIGH_GAP_FIRST = 16'hFE09;
	localparam logic [15:0] HIGH_GAP_LAST = 16'hFE0B;

	// Port register addresses.
	localparam logic [15:0] PORT_A_DATA = 16'h0000;
	localparam logic [15:0] PORT_B_DATA = 16'h0001;
	localparam logic [15:0] PORT_C_DATA = 16'h0002;
	localparam logic [15:0] PORT_D_LEVELS = 16'h0003;
	localparam logic [15:0] PORT_A_DIR = 16'h0004;
	localparam logic [15:0] PORT_B_DIR = 16'h0005;
	localparam logic [15:0] PORT_C_DIR = 16'h0006;
	localparam logic [15:0] IO_GAP_A = 16'h0007;
	localparam logic [15:0] PORT_E_DATA = 16'h0008;
	localparam logic [15:0] PORT_F_DATA = 16'h0009;
	localparam logic [15:0] IO_GAP_B = 16'h000A;
	localparam logic [15:0] IO_GAP_C = 16'h000B;
	localparam logic [15:0] PORT_E_DIR = 16'h000C;
	localparam logic [15:0] PORT_F_DIR = 16'h000D;

	// Implemented pin counts of each port.
	localparam int PORT_A_W = 8;
	localparam int PORT_B_W = 8;
	localparam int PORT_C_W = 7;
	localparam int PORT_D_W = 7;
	localparam int PORT_E_W = 8;
	localparam int PORT_F_W = 6;

	localparam logic [7:0] DIR_RESET = 8'h00;

	typedef enum logic [9:0] {
		REG_PORT = 10'h001,
		REG_OTHER = 10'h002,
		MEM_RAM = 10'h004,
		MEM_FLASH = 10'h008,
		REG_HIGH = 10'h010,
		SLOT_RESERVED = 10'h020,
		MEM_MONITOR = 10'h040,
		REG_PROTECT = 10'h080,
		MEM_VECTOR = 10'h100,
		SLOT_UNIMPL = 10'h200
	} region_t;

endpackage

//--- decode_if.sv
interface decode_if;
	logic [15:0] addr;
	memory_map_pkg::region_t region;

	modport requester (
		output addr,
		input region
	);

	modport decoder (
		input addr,
		output region
	);
endinterface

//--- address_decoder.sv
module address_decoder (
	decode_if.decoder dec
);

	always_comb begin
		if (dec.addr <= memory_map_pkg::IO_PAGE_LAST) begin
			case (dec.addr)
				memory_map_pkg::PORT_A_DATA, memory_map_pkg::PORT_B_DATA,
				memory_map_pkg::PORT_C_DATA, memory_map_pkg::PORT_D_LEVELS,
				memory_map_pkg::PORT_A_DIR, memory_map_pkg::PORT_B_DIR,
				memory_map_pkg::PORT_C_DIR, memory_map_pkg::PORT_E_DATA,
				memory_map_pkg::PORT_F_DATA, memory_map_pkg::PORT_E_DIR,
				memory_map_pkg::PORT_F_DIR: dec.region = memory_map_pkg::REG_PORT;
				memory_map_pkg::IO_GAP_A, memory_map_pkg::IO_GAP_B,
				memory_map_pkg::IO_GAP_C: dec.region = memory_map_pkg::SLOT_UNIMPL;
				default: dec.region = memory_map_pkg::REG_OTHER;
			endcase
		end else if (dec.addr <= memory_map_pkg::RAM_LAST) begin
			dec.region = memory_map_pkg::MEM_RAM;
		end else if (dec.addr <= memory_map_pkg::GAP_LAST) begin
			dec.region = memory_map_pkg::SLOT_UNIMPL;
		end else if (dec.addr <= memory_map_pkg::FLASH_LAST) begin
			dec.region = memory_map_pkg::MEM_FLASH;
		end else if (dec.addr <= memory_map_pkg::HIGH_IO_LAST) begin
			if (dec.addr == memory_map_pkg::HIGH_RSV_A ||
					(dec.addr >= memory_map_pkg::HIGH_RSV_FIRST &&
					dec.addr <= memory_map_pkg::HIGH_RSV_LAST)) begin
				dec.region = memory_map_pkg::SLOT_RESERVED;
			end else if (dec.addr >= memory_map_pkg::HIGH_GAP_FIRST &&
					dec.addr <= memory_map_pkg::HIGH_GAP_LAST) begin
				dec.region = memory_map_pkg::SLOT_UNIMPL;
			end else begin
				dec.region = memory_map_pkg::REG_HIGH;
			end
		end else if (dec.addr <= memory_map_pkg::MONITOR_LAST) begin
			dec.region = memory_map_pkg::MEM_MONITOR;
		end else if (dec.addr == memory_map_pkg::PROTECT_ADDR) begin
			dec.region = memory_map_pkg::REG_PROTECT;
		end else if (dec.addr < memory_map_pkg::VECTOR_FIRST) begin
			dec.region = memory_map_pkg::SLOT_UNIMPL;
		end else begin
			dec.region = memory_map_pkg::MEM_VECTOR;
		end
	end

endmodule

//--- port_slice.sv
module port_slice #(
	parameter int W = 8
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] wdata_i,
	input wire logic data_wr_i,
	input wire logic dir_wr_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] pin_o,
	output logic [W-1:0] pin_oe_n_o,
	output logic [W-1:0] level_o,
	output logic [W-1:0] data_rd_o,
	output logic [W-1:0] dir_rd_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] level_q;
	logic [W-1:0] latch_q;
	logic [W-1:0] dir_q;

	// Pin levels arrive asynchronously; the first stage feeds only the second.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			level_q <= '0;
		end else begin
			meta_q <= pin_i;
			level_q <= meta_q;
		end
	end

	// The output latch has no reset and keeps its contents through one.
	always_ff @(posedge clk_sys_i) begin
		if (data_wr_i) begin
			latch_q <= wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dir_q <= '0;
		end else if (dir_wr_i) begin
			dir_q <= wdata_i;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign pin_o[i] = latch_q[i];
			assign pin_oe_n_o[i] = ~dir_q[i];
			assign data_rd_o[i] = dir_q[i] ? latch_q[i] : level_q[i];
		end
	endgenerate

	assign level_o = level_q;
	assign dir_rd_o = dir_q;

endmodule

//--- address_map_and_port_registers.sv
// Overview of operation
// - Decode full 64 Kbyte space into one target.
// - Unimplemented accesses may request illegal-address reset.
// - Writes to read-only bits change nothing.
// - Reads of write-only bits have no side effects.
// - $0000-$005F selects the I/O register page.
// - $0060-$035F selects the 768-byte RAM.
// - $0360-$7FFF is unimplemented, illegal-address checked.
// - $8000-$FDFF selects the flash array.
// - $FE10-$FEFF selects the 240-byte monitor ROM.
// - $FFD2-$FFFF selects the 46-byte vector area.
// - $FF00-$FFD1 unimplemented except protect register $FF7E.
// - Port D reads live pins, bit 7 zero.
// - Direction registers at fixed offsets, reset to zero.
// - Port F data and direction bits 7:6 read zero.
// - Port C low pins shared with converter inputs.
// - Port D feeds modulator current-sense and fault inputs.
// - Port E pins shared with both timers.
// - Port F pins shared with the serial interfaces.
module address_map_and_port_registers (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic illegal_rst_en_i,
	output logic [7:0] rdata_o,
	output logic [9:0] region_sel_o,
	output logic illegal_rst_o,
	input wire logic [7:0] port_a_pin_i,
	output logic [7:0] port_a_pin_o,
	output logic [7:0] port_a_pin_oe_n_o,
	input wire logic [7:0] port_b_pin_i,
	output logic [7:0] port_b_pin_o,
	output logic [7:0] port_b_pin_oe_n_o,
	input wire logic [6:0] port_c_pin_i,
	output logic [6:0] port_c_pin_o,
	output logic [6:0] port_c_pin_oe_n_o,
	input wire logic [6:0] port_d_pin_i,
	input wire logic [7:0] port_e_pin_i,
	output logic [7:0] port_e_pin_o,
	output logic [7:0] port_e_pin_oe_n_o,
	input wire logic [5:0] port_f_pin_i,
	output logic [5:0] port_f_pin_o,
	output logic [5:0] port_f_pin_oe_n_o,
	output logic converter_input_eight_o,
	output logic converter_input_nine_o,
	output logic [2:0] current_sense_o,
	output logic [3:0] fault_input_o,
	output logic [7:0] timer_pin_level_o,
	output logic [5:0] serial_pin_level_o
);

	////////////////////////////////////////////////////////////////////////////////

	logic rst_meta_q;
	logic rst_n_q;

	// Reset asserts at once and releases two clocks after the pin goes high.
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	decode_if dec ();
	memory_map_pkg::region_t region;
	logic access;
	logic port_hit;

	assign dec.addr = addr_i;
	assign region = dec.region;
	assign access = rd_i | wr_i;
	assign port_hit = region == memory_map_pkg::REG_PORT;

	address_decoder u_decoder (
		.dec(dec)
	);

	// One select line per target, live only while an access is on the bus.
	assign region_sel_o = access ? region : 10'h000;

	////////////////////////////////////////////////////////////////////////////////

	logic port_wr;
	logic wr_a_data, wr_b_data, wr_c_data, wr_e_data, wr_f_data;
	logic wr_a_dir, wr_b_dir, wr_c_dir, wr_e_dir, wr_f_dir;

	// Reserved slots and read-only port D never reach any storage.
	assign port_wr = wr_i & port_hit;
	assign wr_a_data = port_wr && addr_i == memory_map_pkg::PORT_A_DATA;
	assign wr_b_data = port_wr && addr_i == memory_map_pkg::PORT_B_DATA;
	assign wr_c_data = port_wr && addr_i == memory_map_pkg::PORT_C_DATA;
	assign wr_e_data = port_wr && addr_i == memory_map_pkg::PORT_E_DATA;
	assign wr_f_data = port_wr && addr_i == memory_map_pkg::PORT_F_DATA;
	assign wr_a_dir = port_wr && addr_i == memory_map_pkg::PORT_A_DIR;
	assign wr_b_dir = port_wr && addr_i == memory_map_pkg::PORT_B_DIR;
	assign wr_c_dir = port_wr && addr_i == memory_map_pkg::PORT_C_DIR;
	assign wr_e_dir = port_wr && addr_i == memory_map_pkg::PORT_E_DIR;
	assign wr_f_dir = port_wr && addr_i == memory_map_pkg::PORT_F_DIR;

	////////////////////////////////////////////////////////////////////////////////

	logic [7:0] a_level, a_data, a_dir;
	logic [7:0] b_level, b_data, b_dir;
	logic [6:0] c_level, c_data, c_dir;
	logic [6:0] d_level, d_data;
	logic [7:0] e_level, e_data, e_dir;
	logic [5:0] f_level, f_data, f_dir;

	port_slice #(.W(memory_map_pkg::PORT_A_W)) u_port_a (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_q),
		.wdata_i(wdata_i),
		.data_wr_i(wr_a_data),
		.dir_wr_i(wr_a_dir),
		.pin_i(port_a_pin_i),
		.pin_o(port_a_pin_o),
		.pin_oe_n_o(port_a_pin_oe_n_o),
		.level_o(a_level),
		.data_rd_o(a_data),
		.dir_rd_o(a_dir)
	);

	port_slice #(.W(memory_map_pkg::PORT_B_W)) u_port_b (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_q),
		.wdata_i(wdata_i),
		.data_wr_i(wr_b_data),
		.dir_wr_i(wr_b_dir),
		.pin_i(port_b_pin_i),
		.pin_o(port_b_pin_o),
		.pin_oe_n_o(port_b_pin_oe_n_o),
		.level_o(b_level),
		.data_rd_o(b_data),
		.dir_rd_o(b_dir)
	);

	// Bit 7 of port C is not built, so a write to it is simply dropped.
	port_slice #(.W(memory_map_pkg::PORT_C_W)) u_port_c (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_q),
		.wdata_i(wdata_i[6:0]),
		.data_wr_i(wr_c_data),
		.dir_wr_i(wr_c_dir),
		.pin_i(port_c_pin_i),
		.pin_o(port_c_pin_o),
		.pin_oe_n_o(port_c_pin_oe_n_o),
		.level_o(c_level),
		.data_rd_o(c_data),
		.dir_rd_o(c_dir)
	);

	// Port D has no writable state: its direction stays at input forever.
	port_slice #(.W(memory_map_pkg::PORT_D_W)) u_port_d (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_q),
		.wdata_i(wdata_i[6:0]),
		.data_wr_i(1'b0),
		.dir_wr_i(1'b0),
		.pin_i(port_d_pin_i),
		.pin_o(),
		.pin_oe_n_o(),
		.level_o(d_level),
		.data_rd_o(d_data),
		.dir_rd_o()
	);

	port_slice #(.W(memory_map_pkg::PORT_E_W)) u_port_e (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_q),
		.wdata_i(wdata_i),
		.data_wr_i(wr_e_data),
		.dir_wr_i(wr_e_dir),
		.pin_i(port_e_pin_i),
		.pin_o(port_e_pin_o),
		.pin_oe_n_o(port_e_pin_oe_n_o),
		.level_o(e_level),
		.data_rd_o(e_data),
		.dir_rd_o(e_dir)
	);

	port_slice #(.W(memory_map_pkg::PORT_F_W)) u_port_f (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_q),
		.wdata_i(wdata_i[5:0]),
		.data_wr_i(wr_f_data),
		.dir_wr_i(wr_f_dir),
		.pin_i(port_f_pin_i),
		.pin_o(port_f_pin_o),
		.pin_oe_n_o(port_f_pin_oe_n_o),
		.level_o(f_level),
		.data_rd_o(f_data),
		.dir_rd_o(f_dir)
	);

	////////////////////////////////////////////////////////////////////////////////

	// Synchronised pin levels handed to the peripherals that share the pins.
	assign converter_input_eight_o = c_level[0];
	assign converter_input_nine_o = c_level[1];
	assign current_sense_o = d_level[6:4];
	assign fault_input_o = d_level[3:0];
	assign timer_pin_level_o = e_level;
	assign serial_pin_level_o = f_level;

	////////////////////////////////////////////////////////////////////////////////

	logic [7:0] rdata_d;
	logic [7:0] rdata_q;

	// Unbuilt high bits read as zero; a read only samples, it never modifies.
	always_comb begin
		case (addr_i)
			memory_map_pkg::PORT_A_DATA: rdata_d = a_data;
			memory_map_pkg::PORT_B_DATA: rdata_d = b_data;
			memory_map_pkg::PORT_C_DATA: rdata_d = {1'b0, c_data};
			memory_map_pkg::PORT_D_LEVELS: rdata_d = {1'b0, d_data};
			memory_map_pkg::PORT_A_DIR: rdata_d = a_dir;
			memory_map_pkg::PORT_B_DIR: rdata_d = b_dir;
			memory_map_pkg::PORT_C_DIR: rdata_d = {1'b0, c_dir};
			memory_map_pkg::PORT_E_DATA: rdata_d = e_data;
			memory_map_pkg::PORT_F_DATA: rdata_d = {2'h0, f_data};
			memory_map_pkg::PORT_E_DIR: rdata_d = e_dir;
			memory_map_pkg::PORT_F_DIR: rdata_d = {2'h0, f_dir};
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= 8'h00;
		end else if (rd_i) begin
			rdata_q <= port_hit ? rdata_d : 8'h00;
		end
	end

	assign rdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////////////

	logic illegal_q;

	// One-cycle request to the reset logic for any access to a hole.
	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			illegal_q <= 1'b0;
		end else begin
			illegal_q <= access && illegal_rst_en_i &&
				region == memory_map_pkg::SLOT_UNIMPL;
		end
	end

	assign illegal_rst_o = illegal_q;

endmodule

//--- pin_partner.sv
module pin_partner #(
	parameter int W = 8
) (
	input wire logic [W-1:0] ext_i,
	input wire logic [W-1:0] oe_n_i,
	input wire logic [W-1:0] drv_i,
	output logic [W-1:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// A pin shows the device latch while driven by it, otherwise the outside level.
	assign level_o = (oe_n_i & ext_i) | (~oe_n_i & drv_i);
endmodule

//--- address_map_and_port_registers_asserts.sv
module address_map_and_port_registers_asserts (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic illegal_rst_en_i,
	input wire logic [7:0] rdata_o,
	input wire logic [9:0] region_sel_o,
	input wire logic illegal_rst_o,
	input wire logic [7:0] port_a_pin_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acc;
	logic ill_req;
	assign acc = rd_i | wr_i;
	assign ill_req = acc && illegal_rst_en_i && region_sel_o[9];
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);
	AST_IDLE: assert property (!acc |-> region_sel_o == 10'h000)
		else $error("select without access");
	AST_ONEHOT: assert property (acc |-> $onehot(region_sel_o))
		else $error("select not one-hot");
	AST_IO: assert property (acc && addr_i inside {[16'h000E:16'h005F]}
		|-> region_sel_o == 10'h002) else $error("io page select wrong");
	AST_RAM: assert property (acc && addr_i inside {[16'h0060:16'h035F]}
		|-> region_sel_o == 10'h004) else $error("ram select wrong");
	AST_GAP: assert property (acc && addr_i inside {[16'h0360:16'h7FFF]}
		|-> region_sel_o == 10'h200) else $error("gap select wrong");
	AST_FLASH: assert property (acc && addr_i inside {[16'h8000:16'hFDFF]}
		|-> region_sel_o == 10'h008) else $error("flash select wrong");
	AST_MON: assert property (acc && addr_i inside {[16'hFE10:16'hFEFF]}
		|-> region_sel_o == 10'h040) else $error("monitor select wrong");
	AST_VEC: assert property (acc && addr_i >= 16'hFFD2
		|-> region_sel_o == 10'h100) else $error("vector select wrong");
	AST_HOLE: assert property (acc &&
		addr_i inside {[16'hFF00:16'hFF7D], [16'hFF7F:16'hFFD1]} |-> region_sel_o == 10'h200)
		else $error("high hole select wrong");
	AST_ILL_FWD: assert property (ill_req |=> illegal_rst_o)
		else $error("illegal access not reported");
	AST_ILL_CAUSE: assert property (illegal_rst_o |-> $past(ill_req))
		else $error("illegal pulse without cause");
	AST_DIR: assert property (wr_i && addr_i == 16'h0004
		|=> port_a_pin_oe_n_o == ~$past(wdata_i)) else $error("direction write not applied");
	AST_PTD: assert property (rd_i && addr_i == 16'h0003
		|=> rdata_o[7] == 1'b0) else $error("input port bit 7 not zero");
	AST_PTF: assert property (rd_i && addr_i inside {16'h0009, 16'h000D}
		|=> rdata_o[7:6] == 2'b00) else $error("six-pin port top bits not zero");
	cover property (acc && illegal_rst_en_i ##1 illegal_rst_o);
	cover property (acc && region_sel_o == 10'h004);
	cover property (wr_i && addr_i == 16'h0004);
	cover property (acc && region_sel_o == 10'h020);
endmodule
bind address_map_and_port_registers address_map_and_port_registers_asserts
	i_address_map_and_port_registers_asserts (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .rd_i(rd_i), .wr_i(wr_i),
	.illegal_rst_en_i(illegal_rst_en_i), .rdata_o(rdata_o), .region_sel_o(region_sel_o),
	.illegal_rst_o(illegal_rst_o), .port_a_pin_oe_n_o(port_a_pin_oe_n_o));

//--- address_map_and_port_registers_test.sv
module address_map_and_port_registers_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wdata_i = 8'h00;
	logic rd_i = 1'b0;
	logic wr_i = 1'b0;
	logic illegal_rst_en_i = 1'b0;
	logic [7:0] rdata_o;
	logic [9:0] region_sel_o;
	logic illegal_rst_o;
	logic [7:0] a_ext = 8'h55;
	logic [7:0] a_lvl;
	logic [7:0] a_out;
	logic [7:0] a_oe_n;
	logic [6:0] d_pins = 7'h5A;
	logic [2:0] sense;
	logic [3:0] fault;
	logic [7:0] b_out;
	logic [6:0] c_out;
	logic [7:0] e_out;
	logic [5:0] f_out;
	logic [7:0] b_oe_n;
	logic [6:0] c_oe_n;
	logic [7:0] e_oe_n;
	logic [5:0] f_oe_n;
	logic conv8;
	logic conv9;
	logic [7:0] tmr;
	logic [5:0] ser;
	int fails = 0;
	int total_checks = 0;
	logic [15:0] dirs [5] = '{16'h0004, 16'h0005, 16'h0006, 16'h000C, 16'h000D};
	logic [15:0] holes [11] = '{16'h0007, 16'h000A, 16'h000B, 16'h0360, 16'h7FFF, 16'hFE09,
		16'hFE0B, 16'hFF00, 16'hFF7D, 16'hFF7F, 16'hFFD1};
	logic [15:0] map_a [12] = '{16'h0000, 16'h0020, 16'h0060, 16'h035F, 16'h8000, 16'hFDFF,
		16'hFE00, 16'hFE10, 16'hFEFF, 16'hFF7E, 16'hFFD2, 16'hFFFF};
	logic [9:0] map_r [12] = '{10'h001, 10'h002, 10'h004, 10'h004, 10'h008, 10'h008,
		10'h010, 10'h040, 10'h040, 10'h080, 10'h100, 10'h100};
	always #20 clk_sys_i = ~clk_sys_i;
	pin_partner #(.W(8)) i_pin_partner (.ext_i(a_ext), .oe_n_i(a_oe_n), .drv_i(a_out),
		.level_o(a_lvl));
	address_map_and_port_registers i_address_map_and_port_registers (.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .rd_i(rd_i), .wr_i(wr_i),
		.illegal_rst_en_i(illegal_rst_en_i), .rdata_o(rdata_o), .region_sel_o(region_sel_o),
		.illegal_rst_o(illegal_rst_o), .port_a_pin_i(a_lvl), .port_a_pin_o(a_out),
		.port_a_pin_oe_n_o(a_oe_n), .port_b_pin_i(8'hA5), .port_b_pin_o(b_out),
		.port_b_pin_oe_n_o(b_oe_n), .port_c_pin_i(7'h2A), .port_c_pin_o(c_out),
		.port_c_pin_oe_n_o(c_oe_n), .port_d_pin_i(d_pins), .port_e_pin_i(8'h3C),
		.port_e_pin_o(e_out), .port_e_pin_oe_n_o(e_oe_n), .port_f_pin_i(6'h15),
		.port_f_pin_o(f_out), .port_f_pin_oe_n_o(f_oe_n), .converter_input_eight_o(conv8),
		.converter_input_nine_o(conv9), .current_sense_o(sense), .fault_input_o(fault),
		.timer_pin_level_o(tmr), .serial_pin_level_o(ser));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		rd_i = r;
		wr_i = w;
		addr_i = a;
		wdata_i = d;
	endtask
	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 16'h0000, 8'h00);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		bus(1'b1, 1'b0, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		chk({2'b00, rdata_o}, {2'b00, e});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(40 * 2000);
		fails++;
		conclude();
	end
	initial begin
		repeat (3) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		idle(4);
		chk({2'b00, a_oe_n}, 10'h0FF);
		chk({2'b00, b_oe_n}, 10'h0FF);
		chk({3'h0, c_oe_n}, 10'h07F);
		chk({2'b00, e_oe_n}, 10'h0FF);
		chk({4'h0, f_oe_n}, 10'h03F);
		chk({9'h000, conv8}, 10'h000);
		chk({9'h000, conv9}, 10'h001);
		chk({2'b00, tmr}, 10'h03C);
		chk({4'h0, ser}, 10'h015);
		foreach (dirs[i]) rd(dirs[i], 8'h00);
		$display("test reset values done");
		bus(1'b0, 1'b1, 16'h0000, 8'h3C);
		bus(1'b0, 1'b1, 16'h0001, 8'hC3);
		bus(1'b0, 1'b1, 16'h0002, 8'h15);
		bus(1'b0, 1'b1, 16'h0008, 8'h81);
		bus(1'b0, 1'b1, 16'h0004, 8'hF0);
		idle(3);
		chk({2'b00, a_out}, 10'h03C);
		chk({2'b00, b_out}, 10'h0C3);
		chk({3'h0, c_out}, 10'h015);
		chk({2'b00, e_out}, 10'h081);
		chk({2'b00, a_oe_n}, 10'h00F);
		rd(16'h0000, 8'h35);
		rd(16'h0004, 8'hF0);
		$display("test port direction done");
		bus(1'b0, 1'b1, 16'h0003, 8'hFF);
		rd(16'h0003, 8'h5A);
		chk({7'h00, sense}, 10'h005);
		chk({6'h00, fault}, 10'h00A);
		bus(1'b0, 1'b1, 16'h000D, 8'h3F);
		rd(16'h000D, 8'h3F);
		chk({4'h0, f_oe_n}, 10'h000);
		bus(1'b0, 1'b1, 16'h0009, 8'h3F);
		rd(16'h0009, 8'h3F);
		chk({4'h0, f_out}, 10'h03F);
		bus(1'b0, 1'b1, 16'h0006, 8'h7F);
		rd(16'h0006, 8'h7F);
		chk({3'h0, c_oe_n}, 10'h000);
		$display("test unbuilt bits done");
		foreach (map_a[i]) begin
			bus(1'b1, 1'b0, map_a[i], 8'h00);
			#1 chk(region_sel_o, map_r[i]);
		end
		bus(1'b1, 1'b0, 16'hFE05, 8'h00);
		#1 chk(region_sel_o, 10'h020);
		illegal_rst_en_i = 1'b1;
		foreach (holes[i]) begin
			bus(1'b1, 1'b0, holes[i], 8'h00);
			#1 chk(region_sel_o, 10'h200);
			bus(1'b0, 1'b0, holes[i], 8'h00);
			chk({9'h000, illegal_rst_o}, 10'h001);
		end
		illegal_rst_en_i = 1'b0;
		bus(1'b1, 1'b0, 16'h0007, 8'h00);
		bus(1'b0, 1'b0, 16'h0007, 8'h00);
		chk({9'h000, illegal_rst_o}, 10'h000);
		$display("test address map done");
		nrst_i = 1'b0;
		idle(2);
		nrst_i = 1'b1;
		chk({2'b00, a_out}, 10'h03C);
		chk({2'b00, b_out}, 10'h0C3);
		chk({2'b00, a_oe_n}, 10'h0FF);
		idle(4);
		$display("test latch retention done");
		conclude();
	end
endmodule
